// *** logic/power_mode_clock_select.sv ***
/*
 * Power mode control register, oscillator enables, glitch-free core and
 * idle timer clock selection, idle timer, illegal-mode internal reset and
 * halt/idle power-save sequencing.
 * Assumes the two oscillator clocks arrive as one-cycle instruction-cycle
 * ticks synchronous to mclk, and that software uses the register port.
 */
`timescale 1ns/1ps

module power_mode_clock_select (
   // Clock and reset
   input  wire logic       mclk,
   input  wire logic       rst_b,
   // Register port
   input  wire logic [3:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic      [7:0] reg_rdata,
   // Oscillator instruction-cycle ticks
   input  wire logic       high_osc_tick,
   input  wire logic       low_osc_tick,
   // Power-save requests and option
   input  wire logic       halt_req,
   input  wire logic       idle_req,
   input  wire logic       halt_option_enable,
   input  wire logic       multi_input_wakeup,
   // Oscillator enables and clocks out
   output logic            low_osc_enable,
   output logic            high_osc_enable,
   output logic            core_tick,
   output logic            idle_tick,
   // Status
   output logic            idle_interval_event,
   output logic            internal_reset,
   output logic            power_save_halt,
   output logic            power_save_idle
);

   // ************************************************************
   // Register state
   // ************************************************************
   logic [7:0]                  mode_q;
   logic [7:0]                  mode_d;
   logic                        check_q;
   logic                        int_reset_q;
   logic                        startup_q;
   logic                        core_low_q;
   logic                        idle_low_q;
   logic [16:0]                 timer_q;
   logic [16:0]                 timer_d;
   logic [7:0]                  rdata_q;
   logic                        core_tick_q;
   logic                        idle_tick_q;
   logic                        event_q;
   power_mode_pkg::power_save_t ps_q;
   power_mode_pkg::power_save_t ps_d;

   // ************************************************************
   // Decode
   // ************************************************************
   wire        sel_mode    = reg_addr == power_mode_pkg::ADDR_POWER_MODE_CONTROL;
   wire        sel_status  = reg_addr == power_mode_pkg::ADDR_POWER_STATUS;
   wire        write_mode  = reg_wr && sel_mode && !int_reset_q;
   wire [3:0]  nibble      = mode_q[7:4];
   wire        dual_bit    = mode_q[power_mode_pkg::DUAL_CLOCK_ENABLE_BIT];
   wire        core_bit    = mode_q[power_mode_pkg::CORE_CLOCK_SELECT_BIT];
   wire [2:0]  interval    = mode_q[power_mode_pkg::INTERVAL_MSB:0];

   // Legal upper nibble codes
   wire        mode_legal  = nibble == power_mode_pkg::MODE_HIGH_SPEED ||
                             nibble == power_mode_pkg::MODE_HIGH_TO_DUAL ||
                             nibble == power_mode_pkg::MODE_DUAL_CLOCK ||
                             nibble == power_mode_pkg::MODE_DUAL_TO_LOW ||
                             nibble == power_mode_pkg::MODE_LOW_SPEED;

   // Invalid pairing forces both clocks onto the low source
   wire        force_low   = core_bit && !dual_bit;
   wire        want_core_lo = core_bit || force_low;
   wire        want_idle_lo = dual_bit || force_low;

   // Selects move only when neither source ticks, so no pulse is cut
   wire        quiet       = !high_osc_tick && !low_osc_tick;

   wire        core_src    = core_low_q ? low_osc_tick : high_osc_tick;
   wire        idle_src    = idle_low_q ? low_osc_tick : high_osc_tick;

   // Halt freezes the idle timer too; idle keeps it counting
   wire        timer_run   = ps_q != power_mode_pkg::PS_HALT;
   wire        timer_step  = idle_src && timer_run;

   // Interval tap: bits 2-0 only steer the timer
   wire [2:0]  tap_sel     = interval > power_mode_pkg::INTERVAL_MAX_SEL ?
                             power_mode_pkg::INTERVAL_MAX_SEL : interval;
   wire [4:0]  tap_index   = 5'(power_mode_pkg::INTERVAL_TAP_LOW) + {2'b00, tap_sel};
   wire        tap_toggle  = timer_step && (timer_q[tap_index] != timer_d[tap_index]);

   wire        halt_ok     = halt_req && halt_option_enable;
   wire        startup_done = startup_q && timer_step && timer_q == '0;

   // ************************************************************
   // Next-state logic
   // ************************************************************
   always_comb begin
      mode_d = mode_q;
      if (write_mode) begin
         mode_d = reg_wdata;
         // Reserved bit is kept at zero whatever software writes
         mode_d[power_mode_pkg::RESERVED_BIT] = 1'b0;
      end
      if (check_q && !mode_legal) begin
         mode_d = power_mode_pkg::POWER_MODE_RESET;
      end
   end

   always_comb begin
      timer_d = timer_q;
      if (timer_step) begin
         timer_d = timer_q - 17'h00001;
      end
      if (check_q && !mode_legal) begin
         // Preset to 00Fx: 241 to 256 cycles whatever the clock
         timer_d = {1'b0, 8'h00, power_mode_pkg::RESET_PRESET_HIGH[3:0], timer_q[3:0]};
      end else if (ps_q == power_mode_pkg::PS_HALT && multi_input_wakeup) begin
         timer_d = power_mode_pkg::HALT_EXIT_PRESET;
      end
   end

   always_comb begin
      ps_d = ps_q;
      case (ps_q)
         power_mode_pkg::PS_RUN: begin
            if (halt_ok && !startup_q) begin
               ps_d = power_mode_pkg::PS_HALT;
            end else if (idle_req && !startup_q) begin
               ps_d = power_mode_pkg::PS_IDLE;
            end
         end
         power_mode_pkg::PS_IDLE: begin
            if (tap_toggle || multi_input_wakeup) begin
               ps_d = power_mode_pkg::PS_RUN;
            end
         end
         power_mode_pkg::PS_HALT: begin
            if (multi_input_wakeup) begin
               ps_d = power_mode_pkg::PS_RUN;
            end
         end
         default: ps_d = power_mode_pkg::PS_RUN;
      endcase
      if (check_q && !mode_legal) begin
         ps_d = power_mode_pkg::PS_RUN;
      end
   end

   // ************************************************************
   // Mode register
   // ************************************************************
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         mode_q <= power_mode_pkg::POWER_MODE_RESET;
         check_q <= 1'b0;
      end else begin
         mode_q <= mode_d;
         check_q <= write_mode;
      end
   end

   // ************************************************************
   // Internal reset and start-up delay
   // ************************************************************
   // Start-up holds the core off until the timer runs down; it is shared
   // by the illegal-mode reset and by the wake from halt.
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         int_reset_q <= 1'b0;
         startup_q <= 1'b0;
      end else if (check_q && !mode_legal) begin
         int_reset_q <= 1'b1;
         startup_q <= 1'b1;
      end else if (ps_q == power_mode_pkg::PS_HALT && multi_input_wakeup) begin
         startup_q <= 1'b1;
      end else if (startup_done) begin
         int_reset_q <= 1'b0;
         startup_q <= 1'b0;
      end
   end

   // ************************************************************
   // Idle timer and power-save state
   // ************************************************************
   // The idle timer counts in idle and holds in halt until wake; mode writes are still taken
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         timer_q <= '0;
         ps_q <= power_mode_pkg::PS_RUN;
         event_q <= 1'b0;
      end else begin
         timer_q <= timer_d;
         ps_q <= ps_d;
         event_q <= tap_toggle;
      end
   end

   // ************************************************************
   // Glitch-free clock selection
   // ************************************************************
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         core_low_q <= 1'b0;
         idle_low_q <= 1'b0;
      end else if (quiet) begin
         core_low_q <= want_core_lo;
         idle_low_q <= want_idle_lo;
      end
   end

   // Core gets no tick in either power-save mode or during start-up
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         core_tick_q <= 1'b0;
         idle_tick_q <= 1'b0;
      end else begin
         core_tick_q <= core_src && ps_q == power_mode_pkg::PS_RUN && !startup_q;
         idle_tick_q <= timer_step;
      end
   end

   // ************************************************************
   // Read port
   // ************************************************************
   wire [7:0] status_word = {2'b00, core_low_q, idle_low_q, startup_q, int_reset_q,
                             ps_q == power_mode_pkg::PS_HALT, ps_q == power_mode_pkg::PS_IDLE};
   wire [7:0] read_mux    = sel_mode ? mode_q : sel_status ? status_word : power_mode_pkg::READ_UNMAPPED;

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         rdata_q <= power_mode_pkg::READ_UNMAPPED;
      end else begin
         rdata_q <= reg_rd ? read_mux : power_mode_pkg::READ_UNMAPPED;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   // Halt stops both oscillators; register bits still hold their values
   assign low_osc_enable      = mode_q[power_mode_pkg::LOW_OSC_ENABLE_BIT] &&
                                ps_q != power_mode_pkg::PS_HALT;
   assign high_osc_enable     = mode_q[power_mode_pkg::HIGH_OSC_ENABLE_BIT] &&
                                ps_q != power_mode_pkg::PS_HALT;
   assign core_tick           = core_tick_q;
   assign idle_tick           = idle_tick_q;
   assign idle_interval_event = event_q;
   assign internal_reset      = int_reset_q;
   assign power_save_halt     = ps_q == power_mode_pkg::PS_HALT;
   assign power_save_idle     = ps_q == power_mode_pkg::PS_IDLE;
   assign reg_rdata           = rdata_q;

endmodule

// *** logic/power_mode_pkg.sv ***
/*
 * Constants for the power mode and clock select block: register map,
 * field positions, reset values, legal mode codes and timing counts.
 * Assumes a single 40 MHz system clock and a plain register port.
 */
package power_mode_pkg;

   // ************************************************************
   // Register map
   // ************************************************************
   localparam logic [3:0] ADDR_POWER_MODE_CONTROL = 4'h0;
   localparam logic [3:0] ADDR_POWER_STATUS       = 4'h1;

   localparam logic [7:0] POWER_MODE_RESET = 8'h40;
   localparam logic [7:0] READ_UNMAPPED    = 8'h00;

   // ************************************************************
   // Field positions of power_mode_control
   // ************************************************************
   localparam int LOW_OSC_ENABLE_BIT    = 7;
   localparam int HIGH_OSC_ENABLE_BIT   = 6;
   localparam int DUAL_CLOCK_ENABLE_BIT = 5;
   localparam int CORE_CLOCK_SELECT_BIT = 4;
   localparam int RESERVED_BIT          = 3;
   localparam int INTERVAL_MSB          = 2;

   // ************************************************************
   // Legal values of the upper nibble
   // ************************************************************
   localparam logic [3:0] MODE_HIGH_SPEED   = 4'h4;
   localparam logic [3:0] MODE_HIGH_TO_DUAL = 4'hC;
   localparam logic [3:0] MODE_DUAL_CLOCK   = 4'hE;
   localparam logic [3:0] MODE_DUAL_TO_LOW  = 4'hF;
   localparam logic [3:0] MODE_LOW_SPEED    = 4'hB;

   // ************************************************************
   // Idle timer
   // ************************************************************
   localparam int          IDLE_TIMER_WIDTH = 17;
   localparam int          INTERVAL_TAP_LOW = 12;
   localparam logic [2:0]  INTERVAL_MAX_SEL = 3'h4;
   localparam logic [7:0]  RESET_PRESET_HIGH = 8'h0F;
   localparam logic [16:0] HALT_EXIT_PRESET  = 17'h00100;

   typedef enum logic [1:0] {
      PS_RUN,
      PS_IDLE,
      PS_HALT
   } power_save_t;

endpackage

// *** verif/power_mode_chk.sv ***
/* Checker of the power mode block, watching its top ports only.
   Assumes the single clock mclk and the active-low reset rst_b. */
`timescale 1ns/1ps
module power_mode_chk (
   // Clock, reset and register port
   input wire logic       mclk,
   input wire logic       rst_b,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   // Ticks and requests
   input wire logic       high_osc_tick,
   input wire logic       low_osc_tick,
   input wire logic       halt_req,
   input wire logic       halt_option_enable,
   // Block outputs
   input wire logic       low_osc_enable,
   input wire logic       high_osc_enable,
   input wire logic       core_tick,
   input wire logic       internal_reset,
   input wire logic       power_save_halt,
   input wire logic       power_save_idle
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);
   // High oscillator ticks seen while the internal reset holds
   logic [8:0] rst_len_q;
   wire        mode_wr = reg_wr && reg_addr == power_mode_pkg::ADDR_POWER_MODE_CONTROL && !internal_reset;
   wire [3:0]  nib     = reg_wdata[7:4];
   wire        nib_ok  = nib == 4'h4 || nib == 4'hC || nib == 4'hE || nib == 4'hF || nib == 4'hB;
   wire        saving  = power_save_halt || power_save_idle;
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b || !internal_reset) rst_len_q <= 9'h000;
      else if (high_osc_tick) rst_len_q <= rst_len_q + 9'h001;
   end
   a_bad_mode_reset: assert property (mode_wr && !nib_ok |-> !internal_reset ##2 internal_reset)
      else $error("illegal mode did not raise internal reset");
   a_reset_length: assert property ($fell(internal_reset) |-> rst_len_q >= 9'h0EF && rst_len_q <= 9'h101)
      else $error("internal reset length out of range");
   a_reset_mode: assert property (internal_reset |-> high_osc_enable && !low_osc_enable)
      else $error("oscillators not in high speed mode during reset");
   a_osc_follow: assert property (mode_wr && !halt_req && !saving |=> {low_osc_enable, high_osc_enable} == $past(reg_wdata[7:6]))
      else $error("oscillator enables do not follow write");
   a_halt_osc_off: assert property (power_save_halt |-> !low_osc_enable && !high_osc_enable)
      else $error("oscillator running in halt");
   a_save_no_core: assert property (saving && $past(saving) |-> !core_tick)
      else $error("core clock during power save");
   a_core_cause: assert property (core_tick |-> $past(high_osc_tick) || $past(low_osc_tick))
      else $error("core tick without source tick");
   a_halt_refused: assert property (halt_req && !halt_option_enable && !power_save_halt |=> !power_save_halt)
      else $error("halt entered with option off");
   a_rsvd_zero: assert property (reg_rd && reg_addr == power_mode_pkg::ADDR_POWER_MODE_CONTROL |=> !reg_rdata[3])
      else $error("reserved bit read as one");
endmodule
bind power_mode_clock_select power_mode_chk i_power_mode_chk (.mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .high_osc_tick(high_osc_tick),
   .low_osc_tick(low_osc_tick), .halt_req(halt_req), .halt_option_enable(halt_option_enable),
   .low_osc_enable(low_osc_enable), .high_osc_enable(high_osc_enable), .core_tick(core_tick),
   .internal_reset(internal_reset), .power_save_halt(power_save_halt), .power_save_idle(power_save_idle));

// *** verif/power_mode_clock_select_tb.sv ***
/* Self-checking bench of the power mode block.
   Assumes a 40 MHz mclk and ticks made here, synchronous to mclk. */
`timescale 1ns/1ps
module power_mode_clock_select_tb;
   logic mclk, rst_b, reg_wr, reg_rd, hi, lo, halt_req, idle_req, halt_opt, wake;
   logic [3:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata;
   logic lo_en, hi_en, core_tick, idle_tick, ivl_ev, int_rst, halt_st, idle_st;
   int   n_fail = 0;
   int   compares = 0;
   power_mode_clock_select i_power_mode_clock_select (.mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .high_osc_tick(hi),
      .low_osc_tick(lo), .halt_req(halt_req), .idle_req(idle_req), .halt_option_enable(halt_opt),
      .multi_input_wakeup(wake), .low_osc_enable(lo_en), .high_osc_enable(hi_en), .core_tick(core_tick),
      .idle_tick(idle_tick), .idle_interval_event(ivl_ev), .internal_reset(int_rst),
      .power_save_halt(halt_st), .power_save_idle(idle_st));
   // ************************************************************
   // Shared tasks
   // ************************************************************
   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic end_of_test();
      $display("Comparisons %0d, mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge mclk);
      reg_addr <= a; reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   // One tick pulse; ends just after the edge that sampled it
   task automatic tick(input logic h, input logic l);
      @(posedge mclk);
      hi <= h; lo <= l;
      @(posedge mclk);
      hi <= 1'b0; lo <= 1'b0;
      #1;
   endtask
   task automatic req(input logic h, input logic i, input logic w);
      @(posedge mclk);
      halt_req <= h; idle_req <= i; wake <= w;
      @(posedge mclk);
      halt_req <= 1'b0; idle_req <= 1'b0; wake <= 1'b0;
      #1;
   endtask
   // ************************************************************
   // Scenarios
   // ************************************************************
   task automatic t_reset();
      logic [7:0] d;
      rd(4'h0, d); chk("mode after reset", 8'h40, d);
      chk("osc enables", 8'h01, {lo_en, hi_en});
      rd(4'h7, d); chk("unmapped read", 8'h00, d);
   endtask
   task automatic t_modes();
      logic [7:0] d;
      // Reserved bit never written as one; low oscillator on before dual or core select
      logic [7:0] w [9] = '{8'h40, 8'hC1, 8'hE2, 8'hF3, 8'hB4, 8'hF3, 8'hE2, 8'hC1, 8'h40};
      foreach (w[i]) begin
         wr(4'h0, w[i]);
         rd(4'h0, d); chk("mode readback", w[i] & 8'hF7, d);
         chk("legal no reset", 8'h00, int_rst);
         chk("osc enables", w[i][7:6], {lo_en, hi_en});
         tick(1'b1, 1'b0); chk("core on high", !w[i][4], core_tick);
         chk("idle on high", !w[i][5], idle_tick);
         tick(1'b0, 1'b1); chk("core on low", w[i][4], core_tick);
         chk("idle on low", w[i][5], idle_tick);
      end
   endtask
   task automatic t_illegal();
      logic [7:0] d;
      int k;
      for (int n = 0; n < 16; n++) begin
         if (n == 4 || n == 11 || n == 12 || n == 14 || n == 15) continue;
         wr(4'h0, {n[3:0], 4'h0});
         #1 chk("reset not yet", 8'h00, int_rst);
         @(posedge mclk);
         #1 chk("internal reset", 8'h01, int_rst);
         wr(4'h0, 8'hC0);
         for (k = 0; k < 600 && int_rst === 1'b1; k++) tick(1'b1, 1'b0);
         chk("reset length", 8'h01, k >= 240 && k <= 258);
         rd(4'h0, d); chk("mode after reset", 8'h40, d);
      end
   endtask
   task automatic t_save();
      logic [7:0] d;
      int k;
      wr(4'h0, 8'hC2);
      req(1'b1, 1'b0, 1'b0); chk("halt refused", 8'h00, halt_st);
      @(posedge mclk);
      halt_opt <= 1'b1;
      req(1'b1, 1'b0, 1'b0); chk("halt taken", 8'h01, halt_st);
      rd(4'h1, d); chk("status in halt", 8'h02, d);
      chk("osc off in halt", 8'h00, {lo_en, hi_en});
      tick(1'b1, 1'b0); chk("core stopped", 8'h00, core_tick);
      req(1'b0, 1'b0, 1'b1);
      for (k = 0; k < 300 && core_tick !== 1'b1; k++) tick(1'b1, 1'b0);
      chk("core resumes", 8'h01, core_tick);
      rd(4'h0, d); chk("mode kept", 8'hC2, d);
      req(1'b0, 1'b1, 1'b0); chk("idle taken", 8'h01, idle_st);
      chk("osc on in idle", 8'h03, {lo_en, hi_en});
      tick(1'b1, 1'b0); chk("core idle", 8'h00, core_tick);
      chk("timer runs", 8'h01, idle_tick);
      req(1'b0, 1'b0, 1'b1); chk("idle woken", 8'h00, idle_st);
      wr(4'h0, 8'h40);
      req(1'b0, 1'b1, 1'b0);
      for (k = 0; k < 4200 && idle_st === 1'b1; k++) tick(1'b1, 1'b0);
      chk("4k window exit", 8'h01, k <= 4097 && idle_st === 1'b0);
      chk("interval event", 8'h01, ivl_ev);
   endtask
   // ************************************************************
   // Clock, reset and sequence
   // ************************************************************
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   initial begin
      repeat (100000) @(posedge mclk);
      n_fail++;
      end_of_test();
   end
   initial begin
      {rst_b, reg_wr, reg_rd, hi, lo, halt_req, idle_req, halt_opt, wake} = '0;
      reg_addr = 4'h0;
      reg_wdata = 8'h00;
      repeat (16) @(posedge mclk);
      rst_b <= 1'b1;
      t_reset();
      t_modes();
      t_illegal();
      t_save();
      end_of_test();
   end
endmodule
